// File: rtl/bfp_engine.sv
// Flash write state machine with factory stream program and program suspend, behind AXI4-Lite.
// Assumes one clock aclk; reset_pin_n and chip_enable_n arrive asynchronously from pins.
//
// Functional notes
// R1 - After each buffer programs, internal address steps to next 32-word boundary.
// R2 - Host holds first_word_address constant through all streaming into the block.
// R3 - Host aligns first_word_address so low five address bits are zero.
// R4 - Unaligned start address aborts the stream program and sets status bit 4.
// R5 - Host unlocks the target block before setup and confirm commands.
// R6 - Internal address past block end wraps to the block's first address.
// R7 - Factory stream program cannot be suspended; host does no array reads meanwhile.
// R8 - Setup plus confirm clears ready bit 7 during startup checks; host waits.
// R9 - Failed setup check sets bit 4, plus bit 1 if locked, bit 3 if supply bad.
// R10 - After setup, reads return status; a read-status command is buffer data.
// R11 - Bit 7 clear means busy in program phase; bit 0 shows buffer availability.
// R12 - Every fill loads 32 words into consecutive buffer slots from slot zero.
// R13 - Array programming starts only with a full buffer; host pads with 0xFFFF.
// R14 - Out-of-block write during fill exits at once and drops loaded data.
// R15 - Bit 0 clear means buffer moved to array; host waits before next fill.
// R16 - Writes arriving while a full buffer is programming are ignored.
// R17 - Write of 0xFFFF to another block ends program phase and enters exit.
// R18 - Exit sets bit 7, leaves read modes unchanged, any valid command follows.
// R19 - Suspend command halts programming; bits 7 and 2 set, status still read.
// R20 - Suspended programming permits only reads.
// R21 - In suspend only read array, status, identifier, query and resume accepted.
// R22 - In suspend, chip enable high gives standby; reset pin low resets device.
// R23 - Stream program starts with setup 80h followed by confirm D0h.
// R24 - Resume continues suspended programming and clears status bits 7 and 2.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module bfp_engine (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic reset_pin_n,
	input wire logic chip_enable_n,
	output logic standby
);
	import bfp_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic same_block(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a[ADDR_W-1:BLK_LSB] == b[ADDR_W-1:BLK_LSB];
	endfunction

	// Offset wraps inside the 16-bit in-block field, never into the next block
	function automatic logic [ADDR_W-1:0] next_boundary(input logic [ADDR_W-1:0] a);
		return {a[ADDR_W-1:BLK_LSB], 16'(a[BLK_LSB-1:0] + BUF_STEP)};
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic rpin_s1, rpin_s2, ce_s1, ce_s2;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rpin_s1 <= 1'b1;
			rpin_s2 <= 1'b1;
			ce_s1 <= 1'b1;
			ce_s2 <= 1'b1;
		end else begin
			rpin_s1 <= reset_pin_n;
			rpin_s2 <= rpin_s1;
			ce_s1 <= chip_enable_n;
			ce_s2 <= ce_s1;
		end
	end
	logic eng_rst;
	assign eng_rst = !aresetn || !rpin_s2; // [R22]

	// ==========================================================
	// AXI4-Lite write channel
	logic aw_full, w_full;
	logic [7:0] aw_ofs;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	logic next_aw_full, next_w_full;
	logic [ADDR_W-1:0] flash_addr;
	logic [1:0] control;
	logic [BUF_IDX_W-1:0] buf_index;
	logic cyc_we;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_data;
	logic wr_mapped;

	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign next_aw_full = do_write ? 1'b0 : (aw_full || (s_axi_awvalid && s_axi_awready));
	assign next_w_full = do_write ? 1'b0 : (w_full || (s_axi_wvalid && s_axi_wready));
	assign wr_mapped = aw_ofs == OFS_FLASH_ADDR || aw_ofs == OFS_FLASH_DATA || aw_ofs == OFS_CONTROL
		|| aw_ofs == OFS_BUF_INDEX;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_ofs <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			s_axi_awready <= !next_aw_full;
			s_axi_wready <= !next_w_full;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ofs <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_addr <= '0;
			control <= CTL_RESET;
			buf_index <= '0;
		end else if (do_write) begin
			if (aw_ofs == OFS_FLASH_ADDR) begin
				flash_addr <= ADDR_W'(merge(32'(flash_addr), w_data, w_strb));
			end
			if (aw_ofs == OFS_CONTROL) begin
				control <= 2'(merge(32'(control), w_data, w_strb));
			end
			if (aw_ofs == OFS_BUF_INDEX) begin
				buf_index <= BUF_IDX_W'(merge(32'(buf_index), w_data, w_strb));
			end
		end
	end

	// A data register write becomes one device bus write cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_we <= 1'b0;
			cyc_addr <= '0;
			cyc_data <= '0;
		end else begin
			cyc_we <= do_write && aw_ofs == OFS_FLASH_DATA;
			if (do_write && aw_ofs == OFS_FLASH_DATA) begin
				cyc_addr <= flash_addr;
				cyc_data <= DATA_W'(merge(32'(cyc_data), w_data, w_strb));
			end
		end
	end

	// ==========================================================
	// Write state machine
	bfp_state_e state;
	logic [7:0] sr;
	logic [1:0] read_mode;
	logic [ADDR_W-1:0] first_word_address;
	logic [ADDR_W-1:0] prog_addr;
	logic [BUF_IDX_W-1:0] fill_count;
	logic [TMR_W-1:0] timer;
	logic [DATA_W-1:0] wbuf [BUF_WORDS];
	logic [7:0] cmd;
	logic tmr_done;

	assign cmd = cyc_data[7:0];
	assign tmr_done = timer == TMR_W'(1);

	always_ff @(posedge aclk) begin
		if (eng_rst) begin
			state <= BFP_IDLE;
			sr <= SR_RESET;
			read_mode <= RM_ARRAY;
			first_word_address <= '0;
			prog_addr <= '0;
			fill_count <= '0;
			timer <= '0;
		end else begin
			unique case (state)
				BFP_IDLE: begin
					if (cyc_we) begin
						unique case (cmd)
							CMD_FACT_SETUP: begin
								state <= BFP_SETUP; // [R23]
								read_mode <= RM_STATUS;
							end
							CMD_WORD_PROG: begin
								state <= BFP_WDATA;
								read_mode <= RM_STATUS;
							end
							CMD_CLEAR_STATUS: sr <= sr & 8'h85;
							CMD_READ_ARRAY: read_mode <= RM_ARRAY;
							CMD_READ_STATUS: read_mode <= RM_STATUS;
							CMD_READ_ID: read_mode <= RM_ID;
							CMD_QUERY: read_mode <= RM_QUERY;
							default: ;
						endcase
					end
				end
				BFP_SETUP: begin
					if (cyc_we) begin
						if (cmd == CMD_CONFIRM) begin
							state <= BFP_START; // [R23]
							sr[SR_READY] <= 1'b0; // [R8]
							sr[SR_BUFBUSY] <= 1'b1; // [R11]
							first_word_address <= cyc_addr;
							timer <= SETUP_CYC;
						end else begin
							state <= BFP_IDLE;
							sr[SR_SEQERR] <= 1'b1;
							sr[SR_FAIL] <= 1'b1;
						end
					end
				end
				BFP_START: begin
					// Writes during the startup checks are dropped
					timer <= timer - TMR_W'(1);
					if (tmr_done) begin
						if (control[CTL_LOCKED] || !control[CTL_VPP_OK]
							|| first_word_address[BUF_IDX_W-1:0] != '0) begin
							state <= BFP_IDLE;
							sr[SR_READY] <= 1'b1;
							sr[SR_BUFBUSY] <= 1'b0;
							sr[SR_FAIL] <= 1'b1; // [R4] [R9]
							sr[SR_LOCK] <= sr[SR_LOCK] | control[CTL_LOCKED]; // [R9]
							sr[SR_VPPERR] <= sr[SR_VPPERR] | !control[CTL_VPP_OK]; // [R9]
						end else begin
							state <= BFP_FILL;
							sr[SR_BUFBUSY] <= 1'b0; // [R11]
							prog_addr <= first_word_address;
							fill_count <= '0;
						end
					end
				end
				BFP_FILL: begin
					// Any code, suspend included, is plain data here [R7]
					if (cyc_we) begin
						if (!same_block(cyc_addr, first_word_address)) begin
							// Partial fill is dropped; status read mode stays as it was
							state <= BFP_IDLE; // [R14] [R17] [R18]
							sr[SR_READY] <= 1'b1; // [R18]
							fill_count <= '0; // [R14]
						end else begin
							fill_count <= fill_count + BUF_IDX_W'(1); // [R12]
							if (fill_count == BUF_IDX_W'(BUF_WORDS - 1)) begin
								state <= BFP_PROGRAM; // [R13]
								sr[SR_BUFBUSY] <= 1'b1; // [R15]
								timer <= BUF_PROG_CYC;
							end
						end
					end
				end
				BFP_PROGRAM: begin
					timer <= timer - TMR_W'(1); // [R16]
					if (tmr_done) begin
						state <= BFP_FILL;
						sr[SR_BUFBUSY] <= 1'b0; // [R15]
						prog_addr <= next_boundary(prog_addr); // [R1] [R6]
					end
				end
				BFP_WDATA: begin
					if (cyc_we) begin
						if (control[CTL_LOCKED] || !control[CTL_VPP_OK]) begin
							state <= BFP_IDLE;
							sr[SR_FAIL] <= 1'b1;
							sr[SR_LOCK] <= sr[SR_LOCK] | control[CTL_LOCKED];
							sr[SR_VPPERR] <= sr[SR_VPPERR] | !control[CTL_VPP_OK];
						end else begin
							state <= BFP_WPROG;
							sr[SR_READY] <= 1'b0;
							prog_addr <= cyc_addr;
							timer <= WORD_PROG_CYC;
						end
					end
				end
				BFP_WPROG: begin
					if (cyc_we && cmd == CMD_SUSPEND) begin
						// Halts on the edge that takes the suspend write; the timer keeps its remaining count
						state <= BFP_SUSP; // [R19]
						sr[SR_READY] <= 1'b1; // [R19]
						sr[SR_SUSP] <= 1'b1; // [R19]
					end else begin
						timer <= timer - TMR_W'(1);
						if (tmr_done) begin
							state <= BFP_IDLE;
							sr[SR_READY] <= 1'b1;
						end
					end
				end
				BFP_SUSP: begin
					if (cyc_we) begin
						unique case (cmd) // [R20] [R21]
							CMD_READ_ARRAY: read_mode <= RM_ARRAY;
							CMD_READ_STATUS: read_mode <= RM_STATUS;
							CMD_READ_ID: read_mode <= RM_ID;
							CMD_QUERY: read_mode <= RM_QUERY;
							CMD_CONFIRM: begin
								state <= BFP_WPROG; // [R24]
								sr[SR_READY] <= 1'b0; // [R24]
								sr[SR_SUSP] <= 1'b0; // [R24]
							end
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// Buffer slots are written in order from slot zero
	always_ff @(posedge aclk) begin
		if (state == BFP_FILL && cyc_we && same_block(cyc_addr, first_word_address)) begin
			wbuf[fill_count] <= cyc_data; // [R12]
		end
	end

	always_ff @(posedge aclk) begin
		if (eng_rst) begin
			standby <= 1'b0;
		end else begin
			standby <= state == BFP_SUSP && ce_s2; // [R22]
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	logic [7:0] ar_ofs;
	logic [31:0] rd_word;
	logic rd_mapped;
	assign ar_ofs = {s_axi_araddr[7:2], 2'b00};

	always_comb begin
		rd_word = 32'h00000000;
		rd_mapped = 1'b1;
		unique case (ar_ofs)
			OFS_FLASH_ADDR: rd_word = 32'(flash_addr);
			OFS_FLASH_DATA: rd_word = 32'(cyc_data);
			OFS_STATUS: begin
				rd_word[7:0] = sr; // [R10] [R11]
				rd_word[STW_RMODE_LSB +: 2] = read_mode;
				rd_word[STW_STANDBY] = standby;
				rd_word[STW_COUNT_LSB +: BUF_IDX_W] = fill_count;
			end
			OFS_CONTROL: rd_word = 32'(control);
			OFS_PROG_ADDR: rd_word = 32'(prog_addr);
			OFS_BUF_INDEX: rd_word = 32'(buf_index);
			OFS_BUF_DATA: rd_word = 32'(wbuf[buf_index]);
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_mapped ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	sequence s_confirm;
		state == BFP_SETUP && cyc_we && cmd == CMD_CONFIRM;
	endsequence
	sequence s_last_fill;
		state == BFP_FILL && cyc_we && same_block(cyc_addr, first_word_address)
			&& fill_count == BUF_IDX_W'(BUF_WORDS - 1);
	endsequence
	sequence s_suspend_cmd;
		state == BFP_WPROG && cyc_we && cmd == CMD_SUSPEND;
	endsequence

	// Last busy cycle: ready may rise on the edge after the checks resolve
	localparam int SETUP_LAST = (SETUP_NS + CLK_NS - 1) / CLK_NS - 1;
	property p_setup_busy;
		@(posedge aclk) disable iff (eng_rst) s_confirm |=> !sr[SR_READY] ##SETUP_LAST !sr[SR_READY];
	endproperty
	a_setup_busy: assert property (p_setup_busy) else $error("ready not held low during startup"); // [R8]

	property p_unaligned;
		@(posedge aclk) disable iff (eng_rst)
			state == BFP_START && tmr_done && first_word_address[BUF_IDX_W-1:0] != '0
			|=> state == BFP_IDLE && sr[SR_FAIL] && sr[SR_READY];
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("unaligned start not aborted"); // [R4]

	property p_lock_fail;
		@(posedge aclk) disable iff (eng_rst)
			state == BFP_START && tmr_done && control[CTL_LOCKED] |=> sr[SR_FAIL] && sr[SR_LOCK];
	endproperty
	a_lock_fail: assert property (p_lock_fail) else $error("locked block not flagged"); // [R9]

	property p_full_buffer;
		@(posedge aclk) disable iff (eng_rst)
			s_last_fill |=> state == BFP_PROGRAM && sr[SR_BUFBUSY] && fill_count == '0;
	endproperty
	a_full_buffer: assert property (p_full_buffer) else $error("full buffer did not start programming"); // [R13]

	property p_advance;
		@(posedge aclk) disable iff (eng_rst)
			state == BFP_PROGRAM && tmr_done |=> prog_addr == next_boundary($past(prog_addr)) && !sr[SR_BUFBUSY];
	endproperty
	a_advance: assert property (p_advance) else $error("address did not advance one buffer"); // [R1]

	property p_wrap;
		@(posedge aclk) disable iff (eng_rst)
			$changed(prog_addr) && state == BFP_FILL && $past(state) == BFP_PROGRAM
			|-> same_block(prog_addr, $past(prog_addr));
	endproperty
	a_wrap: assert property (p_wrap) else $error("address left its block"); // [R6]

	property p_block_exit;
		@(posedge aclk) disable iff (eng_rst)
			state == BFP_FILL && cyc_we && !same_block(cyc_addr, first_word_address)
			|=> state == BFP_IDLE && sr[SR_READY] && fill_count == '0 && read_mode == $past(read_mode);
	endproperty
	a_block_exit: assert property (p_block_exit) else $error("block change did not exit"); // [R14]

	property p_ignore_writes;
		@(posedge aclk) disable iff (eng_rst) state == BFP_PROGRAM && cyc_we |=> $stable(fill_count);
	endproperty
	a_ignore_writes: assert property (p_ignore_writes) else $error("write taken while programming"); // [R16]

	property p_suspend;
		@(posedge aclk) disable iff (eng_rst) s_suspend_cmd |-> ##[1:2] (sr[SR_READY] && sr[SR_SUSP]);
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend not reported"); // [R19]

	property p_no_factory_suspend;
		@(posedge aclk) disable iff (eng_rst)
			(state == BFP_FILL || state == BFP_PROGRAM) && cyc_we && cmd == CMD_SUSPEND |=> !sr[SR_SUSP];
	endproperty
	a_no_factory_suspend: assert property (p_no_factory_suspend) else $error("stream program suspended"); // [R7]

	property p_suspend_holds;
		@(posedge aclk) disable iff (eng_rst)
			state == BFP_SUSP && !(cyc_we && cmd == CMD_CONFIRM) |=> state == BFP_SUSP;
	endproperty
	a_suspend_holds: assert property (p_suspend_holds) else $error("left suspend without resume"); // [R21]

	property p_resume;
		@(posedge aclk) disable iff (eng_rst)
			state == BFP_SUSP && cyc_we && cmd == CMD_CONFIRM |=> state == BFP_WPROG && !sr[SR_READY] && !sr[SR_SUSP];
	endproperty
	a_resume: assert property (p_resume) else $error("resume did not clear suspend"); // [R24]

	property p_standby;
		@(posedge aclk) disable iff (eng_rst) state == BFP_SUSP && ce_s2 |=> standby;
	endproperty
	a_standby: assert property (p_standby) else $error("no standby in suspend"); // [R22]
endmodule // bfp_engine

// File: rtl/bfp_pkg.sv
// Constants, register map and command codes for the factory stream program engine.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
package bfp_pkg;
	// ==========================================================
	// Bus and array geometry
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BLK_LSB = 16;
	localparam int BUF_WORDS = 32;
	localparam int BUF_IDX_W = 5;
	localparam logic [15:0] BUF_STEP = 16'h0020;
	localparam logic [15:0] PAD_WORD = 16'hFFFF;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_FLASH_ADDR = 8'h00;
	localparam logic [7:0] OFS_FLASH_DATA = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_PROG_ADDR = 8'h10;
	localparam logic [7:0] OFS_BUF_INDEX = 8'h14;
	localparam logic [7:0] OFS_BUF_DATA = 8'h18;

	// Status byte bit positions
	localparam int SR_READY = 7;
	localparam int SR_SEQERR = 5;
	localparam int SR_FAIL = 4;
	localparam int SR_VPPERR = 3;
	localparam int SR_SUSP = 2;
	localparam int SR_LOCK = 1;
	localparam int SR_BUFBUSY = 0;
	localparam logic [7:0] SR_RESET = 8'h80;
	// Status register word fields above the status byte
	localparam int STW_RMODE_LSB = 8;
	localparam int STW_STANDBY = 12;
	localparam int STW_COUNT_LSB = 16;
	// Control register bits
	localparam int CTL_LOCKED = 0;
	localparam int CTL_VPP_OK = 1;
	localparam logic [1:0] CTL_RESET = 2'h2;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_FACT_SETUP = 8'h80;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_WORD_PROG = 8'h40;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ID = 8'h90;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

	// Read modes of the partition
	localparam logic [1:0] RM_ARRAY = 2'h0;
	localparam logic [1:0] RM_STATUS = 2'h1;
	localparam logic [1:0] RM_ID = 2'h2;
	localparam logic [1:0] RM_QUERY = 2'h3;

	// ==========================================================
	// Timing, nanoseconds and derived cycles (least times, rounded up)
	localparam int CLK_NS = 10;
	localparam int SETUP_NS = 500;
	localparam int BUF_PROG_NS = 2000;
	localparam int WORD_PROG_NS = 1000;
	localparam int TMR_W = 16;
	localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'((SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] BUF_PROG_CYC = TMR_W'((BUF_PROG_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [TMR_W-1:0] WORD_PROG_CYC = TMR_W'((WORD_PROG_NS + CLK_NS - 1) / CLK_NS);

	// ==========================================================
	// Engine states
	typedef enum logic [7:0] {
		BFP_IDLE = 8'h01,
		BFP_SETUP = 8'h02,
		BFP_START = 8'h04,
		BFP_FILL = 8'h08,
		BFP_PROGRAM = 8'h10,
		BFP_WDATA = 8'h20,
		BFP_WPROG = 8'h40,
		BFP_SUSP = 8'h80
	} bfp_state_e;
endpackage

// File: tb/bfp_host.sv
// Host programmer model: an AXI4-Lite master for the engine.
// Assumes one write and one read at most under way.
`timescale 1ns/1ps
module bfp_host (
	input wire logic aclk,
	output logic [31:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [31:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// ====================
	// Bus idle at start
	initial begin
		s_axi_awaddr = 32'h0;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 32'h0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end
	// ====================
	// Transfers
	task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Channels may be taken in either order
		fork
			begin
				do @(posedge aclk); while (s_axi_awready !== 1'b1);
				s_axi_awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (s_axi_wready !== 1'b1);
				s_axi_wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule // bfp_host

// File: tb/bfp_engine_bench.sv
// Self-checking bench for the stream program engine.
// Assumes bfp_host as bus master; pins driven here.
`timescale 1ns/1ps
module bfp_engine_bench;
	import bfp_pkg::*;
	logic aclk;
	logic aresetn;
	logic reset_pin_n;
	logic chip_enable_n;
	logic standby;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	int n_errors = 0;
	int n_checks = 0;
	typedef struct {logic w; logic [7:0] a; logic [31:0] v; logic [1:0] e; logic [31:0] m; logic [31:0] x;} bfp_row_s;
	bfp_row_s rows [8] = '{'{1'b0, OFS_STATUS, 32'h0, 2'h0, 32'hFF, 32'h80},
		'{1'b0, OFS_CONTROL, 32'h0, 2'h0, 32'h3, 32'h2}, '{1'b1, OFS_BUF_INDEX, 32'h1F, 2'h0, 32'h0, 32'h0},
		'{1'b0, OFS_BUF_INDEX, 32'h0, 2'h0, 32'h1F, 32'h1F}, '{1'b1, OFS_FLASH_ADDR, 32'h2FFC0, 2'h0, 32'h0, 32'h0},
		'{1'b0, OFS_FLASH_ADDR, 32'h0, 2'h0, 32'hFFFFFF, 32'h2FFC0}, '{1'b1, OFS_STATUS, 32'h0, 2'h2, 32'h0, 32'h0},
		'{1'b0, 8'h1C, 32'h0, 2'h2, 32'hFFFFFFFF, 32'h0}};
	logic [1:0] ctl [4] = '{2'h3, 2'h0, 2'h1, 2'h2};
	logic [7:0] sx [4] = '{8'h92, 8'h98, 8'h9A, 8'h90};
	logic [7:0] rmc [4] = '{CMD_READ_ARRAY, CMD_READ_STATUS, CMD_READ_ID, CMD_QUERY};
	bfp_engine dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .reset_pin_n, .chip_enable_n, .standby);
	bfp_host host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	// ====================
	// Helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic dev(input logic [23:0] a, input logic [15:0] v);
		host_u.wr({24'h0, OFS_FLASH_ADDR}, {8'h0, a}, r);
		host_u.wr({24'h0, OFS_FLASH_DATA}, {16'h0, v}, r);
	endtask
	task automatic rg(input logic [7:0] o, input logic [31:0] m, input logic [31:0] e);
		host_u.rd({24'h0, o}, d, r);
		chk(d & m, e);
	endtask
	task automatic go(input logic [23:0] a, input logic [1:0] c);
		host_u.wr({24'h0, OFS_CONTROL}, {30'h0, c}, r);
		dev(a, {8'h0, CMD_FACT_SETUP});
		dev(a, {8'h0, CMD_CONFIRM});
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ====================
	// Clock and watchdog
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		#500000;
		n_errors++;
		end_of_test();
	end
	// ====================
	// Sequence
	initial begin
		aresetn = 1'b0;
		reset_pin_n = 1'b1;
		chip_enable_n = 1'b0;
		cyc(20);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) host_u.wr({24'h0, rows[i].a}, rows[i].v, r);
			else host_u.rd({24'h0, rows[i].a}, d, r);
			chk({30'h0, r}, {30'h0, rows[i].e});
			if (!rows[i].w) chk(d & rows[i].m, rows[i].x);
		end
		for (int i = 0; i < 4; i++) begin
			go(i == 3 ? 24'h010005 : 24'h010000, ctl[i]);
			rg(OFS_STATUS, 32'h80, 32'h0);
			cyc(60);
			rg(OFS_STATUS, 32'hFF, {24'h0, sx[i]});
			dev(24'h010000, {8'h0, CMD_CLEAR_STATUS});
		end
		go(24'h02FFC0, 2'h2);
		cyc(60);
		rg(OFS_STATUS, 32'h81, 32'h0);
		for (int i = 0; i < 64; i++) begin
			if (i == 32) begin
				cyc(210);
				rg(OFS_STATUS, 32'h1, 32'h0);
				rg(OFS_PROG_ADDR, 32'hFFFFFF, 32'h2FFE0);
				host_u.wr({24'h0, OFS_BUF_INDEX}, 32'h0, r);
				rg(OFS_BUF_DATA, 32'hFFFF, 32'h70);
			end
			dev(24'h02FFC0, i == 0 ? 16'h0070 : (i > 40 ? PAD_WORD : 16'(i)));
			if (i == 30) rg(OFS_STATUS, 32'h1F0001, 32'h1F0000);
			if (i == 31) begin
				dev(24'h02FFC0, {8'h0, CMD_SUSPEND});
				rg(OFS_STATUS, 32'h1F0005, 32'h1);
			end
		end
		cyc(210);
		rg(OFS_PROG_ADDR, 32'hFFFFFF, 32'h20000);
		rg(OFS_BUF_DATA, 32'hFFFF, 32'h20);
		dev(24'h030000, PAD_WORD);
		rg(OFS_STATUS, 32'h81, 32'h80);
		go(24'h040000, 2'h2);
		cyc(60);
		repeat (5) dev(24'h040000, 16'h5555);
		dev(24'h050000, PAD_WORD);
		rg(OFS_STATUS, 32'h1F0081, 32'h80);
		go(24'h040000, 2'h2);
		cyc(60);
		dev(24'h040000, 16'h5555);
		rg(OFS_STATUS, 32'h1F0000, 32'h10000);
		dev(24'h050000, PAD_WORD);
		dev(24'h000010, {8'h0, CMD_WORD_PROG});
		dev(24'h000010, 16'h1234);
		dev(24'h000000, {8'h0, CMD_SUSPEND});
		rg(OFS_STATUS, 32'h84, 32'h84);
		chip_enable_n <= 1'b1;
		cyc(4);
		chk({31'h0, standby}, 32'h1);
		chip_enable_n <= 1'b0;
		dev(24'h000010, {8'h0, CMD_WORD_PROG});
		for (int i = 0; i < 4; i++) begin
			dev(24'h0, {8'h0, rmc[i]});
			rg(OFS_STATUS, 32'h385, {22'h0, 2'(i), 8'h84});
		end
		dev(24'h0, {8'h0, CMD_CONFIRM});
		rg(OFS_STATUS, 32'h84, 32'h0);
		cyc(110);
		rg(OFS_STATUS, 32'h80, 32'h80);
		dev(24'h000010, {8'h0, CMD_WORD_PROG});
		dev(24'h000010, 16'h4321);
		dev(24'h000000, {8'h0, CMD_SUSPEND});
		reset_pin_n <= 1'b0;
		cyc(4);
		reset_pin_n <= 1'b1;
		cyc(4);
		rg(OFS_STATUS, 32'h3FF, 32'h80);
		aresetn <= 1'b0;
		cyc(3);
		chk({31'h0, s_axi_awready}, 32'h0);
		aresetn <= 1'b1;
		rg(OFS_CONTROL, 32'h3, 32'h2);
		end_of_test();
	end
endmodule // bfp_engine_bench
